// [pkg/tmc_pkg.sv]
// constants and types for the transceiver top control register block
`default_nettype none
package tmc_pkg;
  // ==========================================================
  // register map
  localparam logic [6:0] ADDR_TOP   = 7'h00;
  localparam logic [7:0] TOP_POR    = 8'h01;
  // ==========================================================
  // field positions of top_control_reg
  localparam int DIR_BIT    = 7;
  localparam int FSET_BIT   = 6;
  localparam int POL_HI     = 5;
  localparam int POL_LO     = 4;
  localparam int SYNTH_BIT  = 3;
  localparam int XTAL_BIT   = 2;
  localparam int CGEN_BIT   = 1;
  localparam int RSTN_BIT   = 0;
  localparam int IVAL_HI    = 3;
  localparam int IVAL_LO    = 2;
  localparam int SLEEP_BIT  = 1;
  // ==========================================================
  // per_module_off_reg bit positions
  localparam int PM_RX      = 0;
  localparam int PM_PA      = 1;
  localparam int PM_SYNTH   = 2;
  localparam int PM_XTAL    = 3;
  localparam int PM_CGEN    = 4;
  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    POL_BY_DIR     = 2'h0,
    POL_ALL_OFF    = 2'h1,
    POL_PER_MODULE = 2'h2,
    POL_SEQ        = 2'h3
  } tmc_policy_t;
  typedef enum logic [1:0] {
    IVAL_NEVER = 2'h0,
    IVAL_EVERY = 2'h1,
    IVAL_16    = 2'h2,
    IVAL_256   = 2'h3
  } tmc_ival_t;
  localparam logic [7:0] WRAP_16  = 8'h0F;
  localparam logic [7:0] WRAP_256 = 8'hFF;
endpackage
`default_nettype wire

// [pkg/tmc_seq_if.sv]
// carrier between the control block and its sequence counter
`default_nettype none
interface tmc_seq_if;
  logic                seq_done;
  logic                clear;
  tmc_pkg::tmc_ival_t  interval;
  logic                cal_due;
  modport ctl (output seq_done, output clear, output interval, input cal_due);
  modport cnt (input seq_done, input clear, input interval, output cal_due);
endinterface
`default_nettype wire

// [rtl/tmc_seq_counter.sv]
// completed-sequence counter that flags calibration at the chosen interval
`default_nettype none
module tmc_seq_counter #(
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  rst,
  // control side
  tmc_seq_if.cnt     sq
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] wrap;
  logic          cal_reg;

  always_comb begin
    wrap = (sq.interval == tmc_pkg::IVAL_16) ? CW'(tmc_pkg::WRAP_16) : CW'(tmc_pkg::WRAP_256);
  end

  // ==========================================================
  // count, cleared by soft reset
  always_ff @(posedge mclk) begin
    if (rst || sq.clear) begin
      count_reg <= '0;
    end else if (sq.seq_done) begin
      if (count_reg >= wrap) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

  // ==========================================================
  // calibration request on wrap, or on every completed sequence for IVAL_EVERY
  always_ff @(posedge mclk) begin
    if (rst || sq.clear) begin
      cal_reg <= 1'b0;
    end else begin
      unique case (sq.interval)
        tmc_pkg::IVAL_NEVER: cal_reg <= 1'b0;
        tmc_pkg::IVAL_EVERY: cal_reg <= sq.seq_done;
        tmc_pkg::IVAL_16,
        tmc_pkg::IVAL_256:   cal_reg <= sq.seq_done && (count_reg >= wrap);
      endcase
    end
  end
  assign sq.cal_due = cal_reg;

  a_cal_needs_done: assert property (@(posedge mclk) disable iff (rst)
    sq.cal_due |-> $past(sq.seq_done)) else $error("calibration without completed sequence");
  a_count_cleared: assert property (@(posedge mclk) disable iff (rst)
    sq.clear |=> (count_reg == '0)) else $error("sequence count not cleared");
endmodule
`default_nettype wire

// [rtl/tmc_top.sv]
// transceiver top control register with power policy and sequencing control
`default_nettype none
module tmc_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // configuration port
  input  wire logic        cfg_wr_en,
  input  wire logic [6:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  // other configuration registers
  input  wire logic [7:0]  per_module_off_reg,
  input  wire logic        split_data_pins,
  input  wire logic        seq_start_source,
  // pin and sequencer
  input  wire logic        data_io_pin,
  input  wire logic        seq_done_in,
  // controls out
  output logic             direction_select,
  output logic             freq_set_b,
  output logic             rx_chain_off,
  output logic             pa_off,
  output logic             synth_off,
  output logic             xtal_core_off,
  output logic             current_gen_off,
  output logic             defaults_load,
  output logic             chip_sleep,
  output logic             seq_start,
  output logic             cal_request
);
  typedef enum logic [1:0] {SQ_IDLE, SQ_SLEEP, SQ_RUN} tmc_seq_state_t;

  logic [7:0]          top_control_reg;
  logic                wr_top;
  tmc_pkg::tmc_policy_t policy;
  logic                seq_mode;
  logic                pin_s1_reg;
  logic                pin_s2_reg;
  logic                pin_old_reg;
  logic                start_evt;
  logic                sleep_evt;
  tmc_seq_state_t      state_reg;
  logic                start_reg;
  logic                rx_off_next;
  logic                pa_off_next;
  logic                synth_next;
  logic                xtal_next;
  logic                cgen_next;

  tmc_seq_if sq ();

  assign wr_top   = cfg_wr_en && (cfg_addr == tmc_pkg::ADDR_TOP);
  assign policy   = tmc_pkg::tmc_policy_t'(top_control_reg[tmc_pkg::POL_HI:tmc_pkg::POL_LO]);
  // sequencing is refused in transmit, so a bad host write cannot start it
  assign seq_mode = (policy == tmc_pkg::POL_SEQ) && !top_control_reg[tmc_pkg::DIR_BIT];

  // ==========================================================
  // register write and read
  always_ff @(posedge mclk) begin
    if (rst) begin
      top_control_reg <= tmc_pkg::TOP_POR;
    end else if (wr_top) begin
      top_control_reg <= cfg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else begin
      cfg_rdata <= (cfg_addr == tmc_pkg::ADDR_TOP) ? top_control_reg : 8'h00;
    end
  end

  // held for as long as the bit stays low; released by the host writing it high or by rst loading TOP_POR
  assign defaults_load = !top_control_reg[tmc_pkg::RSTN_BIT];

  // ==========================================================
  // data pin synchroniser and start edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_reg  <= 1'b1;
      pin_s2_reg  <= 1'b1;
      pin_old_reg <= 1'b1;
    end else begin
      pin_s1_reg  <= data_io_pin;
      pin_s2_reg  <= pin_s1_reg;
      pin_old_reg <= pin_s2_reg;
    end
  end

  assign start_evt = seq_mode && split_data_pins && !seq_start_source
                     && pin_old_reg && !pin_s2_reg;
  assign sleep_evt = seq_mode && wr_top && cfg_wdata[tmc_pkg::SLEEP_BIT]
                     && !top_control_reg[tmc_pkg::SLEEP_BIT];

  // ==========================================================
  // sequencing state
  always_ff @(posedge mclk) begin
    if (rst || defaults_load) begin
      state_reg <= SQ_IDLE;
    end else if (!seq_mode) begin
      state_reg <= SQ_IDLE;
    end else if (sleep_evt) begin
      state_reg <= SQ_SLEEP;
    end else begin
      unique case (state_reg)
        SQ_IDLE,
        SQ_SLEEP: if (start_evt) state_reg <= SQ_RUN;
        SQ_RUN:   if (seq_done_in) state_reg <= SQ_SLEEP;
        default:  state_reg <= SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_evt && !sleep_evt && !defaults_load && (state_reg != SQ_RUN);
    end
  end
  assign seq_start  = start_reg;
  assign chip_sleep = (state_reg == SQ_SLEEP);

  // ==========================================================
  // calibration interval counter
  assign sq.seq_done = seq_mode && (state_reg == SQ_RUN) && seq_done_in;
  assign sq.clear    = defaults_load;
  assign sq.interval = tmc_pkg::tmc_ival_t'(top_control_reg[tmc_pkg::IVAL_HI:tmc_pkg::IVAL_LO]);

  tmc_seq_counter #(.CW(8)) u_count (
    .mclk (mclk),
    .rst  (rst),
    .sq   (sq.cnt)
  );
  assign cal_request = sq.cal_due;

  // ==========================================================
  // power-down decode
  always_comb begin
    rx_off_next = 1'b1;
    pa_off_next = 1'b1;
    synth_next  = top_control_reg[tmc_pkg::SYNTH_BIT];
    xtal_next   = top_control_reg[tmc_pkg::XTAL_BIT];
    cgen_next   = top_control_reg[tmc_pkg::CGEN_BIT];
    unique case (policy)
      tmc_pkg::POL_BY_DIR: begin
        rx_off_next = top_control_reg[tmc_pkg::DIR_BIT];
        pa_off_next = !top_control_reg[tmc_pkg::DIR_BIT];
      end
      tmc_pkg::POL_ALL_OFF: begin
        rx_off_next = 1'b1;
        pa_off_next = 1'b1;
      end
      tmc_pkg::POL_PER_MODULE: begin
        rx_off_next = per_module_off_reg[tmc_pkg::PM_RX];
        pa_off_next = per_module_off_reg[tmc_pkg::PM_PA];
        synth_next  = per_module_off_reg[tmc_pkg::PM_SYNTH];
        xtal_next   = per_module_off_reg[tmc_pkg::PM_XTAL];
        cgen_next   = per_module_off_reg[tmc_pkg::PM_CGEN];
      end
      tmc_pkg::POL_SEQ: begin
        // bits 3:1 are sequencing controls here, the sequence owns power
        rx_off_next = (state_reg != SQ_RUN);
        pa_off_next = 1'b1;
        synth_next  = (state_reg != SQ_RUN);
        xtal_next   = (state_reg == SQ_SLEEP);
        cgen_next   = (state_reg == SQ_SLEEP);
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      direction_select <= 1'b0;
      freq_set_b       <= 1'b0;
      rx_chain_off     <= 1'b1;
      pa_off           <= 1'b1;
      synth_off        <= 1'b1;
      xtal_core_off    <= 1'b0;
      current_gen_off  <= 1'b0;
    end else begin
      direction_select <= top_control_reg[tmc_pkg::DIR_BIT];
      freq_set_b       <= top_control_reg[tmc_pkg::FSET_BIT];
      rx_chain_off     <= rx_off_next;
      pa_off           <= pa_off_next;
      synth_off        <= synth_next;
      xtal_core_off    <= xtal_next;
      current_gen_off  <= cgen_next;
    end
  end

  // ==========================================================
  // checks
  a_dir_follows: assert property (@(posedge mclk) disable iff (rst)
    wr_top ##2 1'b1 |-> direction_select == $past(cfg_wdata[tmc_pkg::DIR_BIT], 2))
    else $error("direction does not follow write");
  a_fset_follows: assert property (@(posedge mclk) disable iff (rst)
    wr_top ##2 1'b1 |-> freq_set_b == $past(cfg_wdata[tmc_pkg::FSET_BIT], 2))
    else $error("frequency set does not follow write");
  a_dir_policy: assert property (@(posedge mclk) disable iff (rst)
    policy == tmc_pkg::POL_BY_DIR |=> rx_chain_off == direction_select && pa_off == !rx_chain_off)
    else $error("direction policy wrong");
  a_all_off: assert property (@(posedge mclk) disable iff (rst)
    policy == tmc_pkg::POL_ALL_OFF |=> rx_chain_off && pa_off)
    else $error("all-off policy wrong");
  a_per_module: assert property (@(posedge mclk) disable iff (rst)
    policy == tmc_pkg::POL_PER_MODULE |=> synth_off == $past(per_module_off_reg[tmc_pkg::PM_SYNTH]))
    else $error("per-module policy wrong");
  a_synth_bit: assert property (@(posedge mclk) disable iff (rst)
    policy != tmc_pkg::POL_SEQ && policy != tmc_pkg::POL_PER_MODULE
      |=> synth_off == $past(top_control_reg[tmc_pkg::SYNTH_BIT]))
    else $error("synthesizer power-down wrong");
  a_xtal_bit: assert property (@(posedge mclk) disable iff (rst)
    policy inside {tmc_pkg::POL_BY_DIR, tmc_pkg::POL_ALL_OFF}
      |=> xtal_core_off == $past(top_control_reg[tmc_pkg::XTAL_BIT]))
    else $error("crystal core power-down wrong");
  a_soft_keeps: assert property (@(posedge mclk) disable iff (rst)
    !wr_top |=> $stable(top_control_reg)) else $error("register changed without write");
  a_sleep_entry: assert property (@(posedge mclk) disable iff (rst)
    sleep_evt && !defaults_load |=> chip_sleep) else $error("sleep trigger missed");
  a_start_edge: assert property (@(posedge mclk) disable iff (rst)
    seq_start |-> $past(start_evt) && !$past(pin_s2_reg)) else $error("start without falling edge");
endmodule
`default_nettype wire

// [dv/tmc_host_model.sv]
// host model driving the configuration port of the top control register
`default_nettype none
module tmc_host_model (
  // clock
  input  wire logic       mclk,
  // configuration port
  output var  logic       cfg_wr_en,
  output var  logic [6:0] cfg_addr,
  output var  logic [7:0] cfg_wdata,
  input  wire logic [7:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr_en = 1'b0;
    cfg_addr  = 7'h7F;
    cfg_wdata = 8'hA5;
  end
  // one byte write; lines carry inverted junk once the strobe drops
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    cfg_wr_en <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_wr_en <= 1'b0;
    cfg_addr  <= ~a;
    cfg_wdata <= ~d;
  endtask
  // read port is registered, so hold the address two edges
  task automatic rd(output logic [7:0] d);
    @(posedge mclk);
    cfg_addr <= 7'h00;
    repeat (2) @(posedge mclk);
    d = cfg_rdata;
    cfg_addr <= 7'h55;
  endtask
  // soft reset only ends once bit 0 is written back high
  task automatic finish_reset(input logic [7:0] v);
    wr(7'h00, v | 8'h01);
  endtask
  // sequencing layout always carries receive direction
  task automatic seq_write(input logic [1:0] iv, input logic fs, input logic sl, input logic rn);
    wr(7'h00, {1'b0, fs, 2'h3, iv, sl, rn});
  endtask
endmodule
`default_nettype wire

// [dv/transceiver_main_control_register_tb.sv]
// self-checking bench for the transceiver top control register
`default_nettype none
module transceiver_main_control_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       cfg_wr_en;
  logic [6:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata, v, w, rb;
  logic [7:0] pm = 8'h00;
  logic       split = 1'b1, src = 1'b0, pin = 1'b1, done = 1'b0;
  logic       dir, fsb, rxo, pao, syo, xto, cgo, dload, slp, sst, cal;
  int         num_errors = 0, checks_done = 0, starts = 0, cals = 0, i, k, c0;
  logic [7:0] corner [5] = '{8'h80, 8'h91, 8'h6F, 8'hAB, 8'h0F};
  wire  [7:0] obs = {1'b0, dir, fsb, rxo, pao, syo, xto, cgo};
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if (sst === 1'b1) starts <= starts + 1;
    if (cal === 1'b1) cals <= cals + 1;
  end
  tmc_host_model host (.mclk(mclk), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  tmc_top DUT (.mclk(mclk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .per_module_off_reg(pm),
    .split_data_pins(split), .seq_start_source(src), .data_io_pin(pin),
    .seq_done_in(done), .direction_select(dir), .freq_set_b(fsb), .rx_chain_off(rxo),
    .pa_off(pao), .synth_off(syo), .xtal_core_off(xto), .current_gen_off(cgo),
    .defaults_load(dload), .chip_sleep(slp), .seq_start(sst), .cal_request(cal));
  // ==========================================================
  // helpers
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // controls expected outside sequencing; per-module policy takes all five from m
  function automatic logic [7:0] exp_ctl(input logic [7:0] r, input logic [7:0] m);
    logic [4:0] pw;
    case (r[5:4])
      2'h0: pw = {r[7], ~r[7], r[3], r[2], r[1]};
      2'h1: pw = {2'b11, r[3], r[2], r[1]};
      default: pw = {m[0], m[1], m[2], m[3], m[4]};
    endcase
    return {1'b0, r[7], r[6], pw};
  endfunction
  task automatic seq_run();
    int s0;
    s0 = starts;
    @(posedge mclk) pin <= 1'b0;
    for (int n = 0; n < 12 && starts == s0; n++) @(posedge mclk);
    chk("seq_start", starts - s0, 1);
    if (starts == s0) complete_run();
    chk("rx_chain_off in run", rxo, 0);
    chk("synth_off in run", syo, 0);
    pin <= 1'b1;
    @(posedge mclk) done <= 1'b1;
    @(posedge mclk) done <= 0;
    settle();
    chk("chip_sleep after done", slp, 1);
    chk("xtal_core_off in sleep", xto, 1);
    chk("current_gen_off in sleep", cgo, 1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(91));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    settle();
    chk("controls after reset", obs, exp_ctl(8'h01, pm));
    $display("test reset done");
    for (i = 0; i < 45; i++) begin
      v = (i < 5) ? corner[i] : 8'($urandom);
      if (v[5:4] == 2'h3) v[5] = 1'b0;
      v[0] = 1'b1;
      w = 8'($urandom);
      @(posedge mclk) pm <= w;
      host.wr(7'h00, v);
      host.wr(7'($urandom_range(1, 127)), ~v);
      settle();
      chk("controls", obs, exp_ctl(v, w));
      host.rd(rb);
      chk("readback", rb, v);
    end
    $display("test plain policies done");
    // soft reset must leave the register itself untouched
    host.wr(7'h00, 8'h4E);
    settle();
    chk("defaults_load", dload, 1);
    host.rd(rb);
    chk("readback in soft reset", rb, 8'h4E);
    host.finish_reset(8'h4E);
    settle();
    chk("defaults_load", dload, 0);
    $display("test soft reset done");
    // 256 sequences per interval; soft reset clears the count first
    for (i = 0; i < 4; i++) begin
      host.seq_write(i[1:0], i[0], 1'b0, 1'b0);
      host.seq_write(i[1:0], i[0], 1'b0, 1'b1);
      settle();
      chk("freq_set_b", fsb, i[0]);
      chk("pa_off", pao, 1);
      c0 = cals;
      for (k = 0; k < 256; k++) seq_run();
      repeat (4) @(posedge mclk);
      chk("cal count", cals - c0, (i == 0) ? 0 : (i == 1) ? 256 : (i == 2) ? 16 : 1);
    end
    $display("test sequencing done");
    host.seq_write(2'h0, 1'b0, 1'b0, 1'b0);
    host.seq_write(2'h0, 1'b0, 1'b0, 1'b1);
    settle();
    chk("chip_sleep idle", slp, 0);
    host.seq_write(2'h0, 1'b0, 1'b1, 1'b1);
    settle();
    chk("chip_sleep on rise", slp, 1);
    chk("xtal_core_off on rise", xto, 1);
    // start source combinations that must not start a sequence
    for (k = 0; k < 3; k++) begin
      @(posedge mclk);
      split <= (k == 2);
      src <= (k != 0);
      c0 = starts;
      @(posedge mclk) pin <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("no seq_start", starts - c0, 0);
      pin <= 1'b1;
      repeat (4) @(posedge mclk);
    end
    $display("test sleep and start source done");
    // policy 11 with transmit selected must not run the sequence
    @(posedge mclk);
    split <= 1'b1;
    src <= 1'b0;
    host.wr(7'h00, 8'hB1);
    settle();
    c0 = starts;
    @(posedge mclk) pin <= 1'b0;
    repeat (10) @(posedge mclk);
    chk("no seq_start in transmit", starts - c0, 0);
    chk("chip_sleep in transmit", slp, 0);
    chk("direction in transmit", dir, 1);
    pin <= 1'b1;
    repeat (4) @(posedge mclk);
    $display("test transmit refusal done");
    complete_run();
  end
endmodule
`default_nettype wire
